// ===== core/sid_decode.sv
// sid_decode: decodes and executes a split interrupt transfer descriptor
// assumes: transaction engine answers txn_req with txn_ack, then txn_done
//
// Behaviour
// R1 - bit 46 selects split or high-speed
// R2 - decode interrupt kind and OUT/IN token
// R3 - function address from bits 41..35
// R4 - endpoint from bits 34..32 plus bit 31
// R5 - packets limited to maximum packet length
// R6 - software keeps full/low-speed packets within 64
// R7 - byte count bits 17..3, at most 4 kB
// R8 - software sets valid only with payload
// R9 - clear valid on completion or fatal error
// R10 - polling period two to the b-1 microframes
// R11 - software writes active equal to valid
// R12 - error counter is retry budget, decremented
// R13 - invalid descriptor causes no bus traffic
// R14 - reserved bits ignored, written back as zero
`timescale 1ns/1ps
module sid_decode #(
	parameter int TIMER_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// descriptor load
	input wire logic load,
	input wire logic [31:0] descriptor_word0,
	input wire logic [31:0] descriptor_word1,
	input wire logic [7:0] uframe,
	input wire logic [1:0] err_budget,
	// microframe timing
	input wire logic uframe_tick,
	// transaction engine
	output logic txn_req,
	output sid_pkg::sid_txn_t txn,
	input wire logic txn_ack,
	input wire logic txn_done,
	input wire logic [10:0] txn_bytes,
	input wire logic txn_error,
	input wire logic txn_fatal,
	// status and write-back
	output sid_pkg::sid_desc_t desc,
	output logic busy,
	output logic [1:0] err_left,
	output logic wb_valid,
	output logic wb_fatal,
	output logic [31:0] wb_word0
);
	initial begin
		if (TIMER_W < 9 || TIMER_W > 16) $error("sid_decode: TIMER_W out of range");
	end
	// ****************************************
	// state
	// ****************************************
	typedef enum logic [4:0] {
		SID_IDLE = 5'h01,
		SID_WAIT = 5'h02,
		SID_REQ = 5'h04,
		SID_RUN = 5'h08,
		SID_WB = 5'h10
	} sid_state_t;
	sid_state_t state, next_state;
	sid_pkg::sid_desc_t next_desc, ld;
	sid_pkg::sid_txn_t next_txn;
	logic [14:0] remaining, next_remaining;
	logic [1:0] next_err_left;
	logic [3:0] poll_exp, next_poll_exp, ld_exp;
	logic next_txn_req, next_busy, next_wb_valid, next_wb_fatal, fatal, next_fatal;
	logic [31:0] next_wb_word0;
	logic [10:0] pkt_len, took;
	logic load_go, bad, poll_fire;
	// ****************************************
	// field extraction
	// ****************************************
	always_comb begin
		ld.split = descriptor_word1[sid_pkg::SPLIT_POS-32]; // [R1]
		ld.kind = descriptor_word1[sid_pkg::KIND_LO-32 +: 2]; // [R2]
		ld.token = descriptor_word1[sid_pkg::TOKEN_LO-32 +: 2]; // [R2]
		ld.addr = descriptor_word1[sid_pkg::ADDR_LO-32 +: 7]; // [R3]
		ld.endp = {descriptor_word1[sid_pkg::ENDP_UP_LO-32 +: 3],
			descriptor_word0[sid_pkg::ENDP_LSB_POS]}; // [R4]
		ld.maxpkt = descriptor_word0[sid_pkg::MAXPKT_LO +: 11]; // [R5]
		ld.count = descriptor_word0[sid_pkg::COUNT_LO +: 15]; // [R7]
		ld.valid = descriptor_word0[sid_pkg::VALID_POS];
		// bits 47, 30..29, 2..1 never read [R14]
		ld_exp = sid_pkg::POLL_EXP_MIN; // [R10]
		for (int i = 0; i < 5; i++) begin
			if (uframe[sid_pkg::UFRAME_RATE_LO + i]) begin
				ld_exp = sid_pkg::POLL_EXP_MIN + 4'(i + 1);
			end
		end
		bad = (ld.kind != sid_pkg::KIND_INTR) || (ld.token[1]) ||
			(ld.count > sid_pkg::COUNT_LIMIT) ||
			(ld.maxpkt == 11'h000 && ld.count != 15'h0000); // [R2] [R7]
		load_go = load && state == SID_IDLE;
		pkt_len = (remaining > {4'h0, desc.maxpkt}) ? desc.maxpkt : remaining[10:0]; // [R5]
		took = (txn_bytes > txn.len) ? txn.len : txn_bytes;
	end
	sid_poll_timer #(
		.CNT_W(TIMER_W)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.restart(load_go),
		.tick(uframe_tick),
		.exp(poll_exp),
		.fire(poll_fire)
	);
	// ****************************************
	// sequencing
	// ****************************************
	always_comb begin
		next_state = state;
		next_desc = desc;
		next_txn = txn;
		next_remaining = remaining;
		next_err_left = err_left;
		next_poll_exp = poll_exp;
		next_txn_req = txn_req;
		next_wb_valid = 1'b0;
		next_wb_fatal = 1'b0;
		next_wb_word0 = wb_word0;
		next_fatal = fatal;
		case (state)
			SID_IDLE: begin
				if (load_go) begin
					next_desc = ld;
					next_remaining = ld.count;
					next_err_left = err_budget;
					next_poll_exp = ld_exp;
					next_fatal = bad;
					if (ld.valid) begin // [R13]
						next_state = bad ? SID_WB : SID_WAIT;
					end
				end
			end
			SID_WAIT: begin
				if (poll_fire) begin // [R10]
					next_txn.split = desc.split; // [R1]
					next_txn.pid_in = desc.token == sid_pkg::TOKEN_IN; // [R2]
					next_txn.addr = desc.addr; // [R3]
					next_txn.endp = desc.endp; // [R4]
					next_txn.len = pkt_len; // [R5]
					next_txn_req = 1'b1;
					next_state = SID_REQ;
				end
			end
			SID_REQ: begin
				if (txn_ack) begin
					next_txn_req = 1'b0;
					next_state = SID_RUN;
				end
			end
			SID_RUN: begin
				if (txn_done) begin
					if (txn_fatal) begin
						next_fatal = 1'b1;
						next_state = SID_WB;
					end else if (txn_error) begin
						if (err_left == 2'h0) begin // [R12]
							next_fatal = 1'b1;
							next_state = SID_WB;
						end else begin
							next_err_left = err_left - 2'h1; // [R12]
							next_txn_req = 1'b1;
							next_state = SID_REQ;
						end
					end else begin
						next_remaining = remaining - {4'h0, took};
						if (next_remaining == 15'h0000 || took < txn.len) begin
							next_state = SID_WB;
						end else begin
							next_state = SID_WAIT;
						end
					end
				end
			end
			SID_WB: begin
				next_desc.valid = 1'b0; // [R9]
				next_wb_valid = 1'b1;
				next_wb_fatal = fatal;
				next_wb_word0 = {desc.endp[0], sid_pkg::RESERVED_LOW_ZERO, desc.maxpkt,
					remaining, sid_pkg::RESERVED_LOW_ZERO, 1'b0}; // [R9] [R14]
				next_state = SID_IDLE;
			end
			default: begin
				next_state = SID_IDLE;
				next_txn_req = 1'b0;
			end
		endcase
		next_busy = next_state != SID_IDLE;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= SID_IDLE;
			desc <= '0;
			txn <= '0;
			remaining <= '0;
			err_left <= '0;
			poll_exp <= sid_pkg::POLL_EXP_MIN;
			txn_req <= 1'b0;
			busy <= 1'b0;
			wb_valid <= 1'b0;
			wb_fatal <= 1'b0;
			wb_word0 <= '0;
			fatal <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			desc <= next_desc;
			txn <= next_txn;
			remaining <= next_remaining;
			err_left <= next_err_left;
			poll_exp <= next_poll_exp;
			txn_req <= next_txn_req;
			busy <= next_busy;
			wb_valid <= next_wb_valid;
			wb_fatal <= next_wb_fatal;
			wb_word0 <= next_wb_word0;
			fatal <= next_fatal;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	sequence s_loaded;
		ce && load_go;
	endsequence
	sequence s_err_exhaust;
		ce && state == SID_RUN && txn_done && !txn_fatal && txn_error && err_left == 2'h0;
	endsequence
	property p_split;
		@(posedge clk) disable iff (rst)
		s_loaded |=> desc.split == $past(descriptor_word1[14]);
	endproperty
	a_split: assert property (p_split) else $error("split flag mis-decoded"); // [R1]
	property p_token;
		@(posedge clk) disable iff (rst)
		txn_req |-> txn.pid_in == (desc.token == sid_pkg::TOKEN_IN) && txn.split == desc.split;
	endproperty
	a_token: assert property (p_token) else $error("token or split wrong"); // [R2]
	property p_addr;
		@(posedge clk) disable iff (rst)
		s_loaded |=> desc.addr == $past(descriptor_word1[9:3]);
	endproperty
	a_addr: assert property (p_addr) else $error("address mis-decoded"); // [R3]
	property p_endp;
		@(posedge clk) disable iff (rst)
		s_loaded |=> desc.endp == {$past(descriptor_word1[2:0]), $past(descriptor_word0[31])};
	endproperty
	a_endp: assert property (p_endp) else $error("endpoint mis-decoded"); // [R4]
	property p_len;
		@(posedge clk) disable iff (rst)
		txn_req |-> txn.len <= desc.maxpkt && {4'h0, txn.len} <= remaining;
	endproperty
	a_len: assert property (p_len) else $error("packet exceeds limit"); // [R5]
	property p_count;
		@(posedge clk) disable iff (rst)
		s_loaded |=> desc.count == $past(descriptor_word0[17:3]) && remaining == desc.count;
	endproperty
	a_count: assert property (p_count) else $error("byte count mis-decoded"); // [R7]
	property p_wb;
		@(posedge clk) disable iff (rst)
		wb_valid |-> !desc.valid && wb_word0[2:0] == 3'h0 && wb_word0[30:29] == 2'h0;
	endproperty
	a_wb: assert property (p_wb) else $error("write-back leaves valid or reserved set"); // [R9] [R14]
	property p_exhaust;
		@(posedge clk) disable iff (rst)
		s_err_exhaust |=> state == SID_WB ##1 wb_valid && wb_fatal;
	endproperty
	a_exhaust: assert property (p_exhaust) else $error("exhausted retries not fatal"); // [R12]
	property p_retry;
		@(posedge clk) disable iff (rst)
		ce && state == SID_RUN && txn_done && !txn_fatal && txn_error && err_left != 2'h0
		|=> err_left == $past(err_left) - 2'h1 && txn_req;
	endproperty
	a_retry: assert property (p_retry) else $error("retry budget not decremented"); // [R12]
	property p_skip;
		@(posedge clk) disable iff (rst)
		(s_loaded and !descriptor_word0[0]) |=> state == SID_IDLE && !txn_req;
	endproperty
	a_skip: assert property (p_skip) else $error("invalid descriptor started"); // [R13]
	property p_poll;
		@(posedge clk) disable iff (rst)
		ce && state == SID_WAIT && !poll_fire |=> !txn_req;
	endproperty
	a_poll: assert property (p_poll) else $error("request before polling period"); // [R10]
endmodule : sid_decode

// ===== core/sid_pkg.sv
// sid_pkg: constants, field layout and carrier types of the split descriptor decoder
// assumes: descriptor words arrive as plain 32-bit words from buffer memory
package sid_pkg;
	// ****************************************
	// descriptor field positions (descriptor bit numbers) and uframe rate field low bit
	// ****************************************
	localparam int SPLIT_POS = 46;
	localparam int KIND_LO = 44;
	localparam int TOKEN_LO = 42;
	localparam int ADDR_LO = 35;
	localparam int ENDP_UP_LO = 32;
	localparam int ENDP_LSB_POS = 31;
	localparam int MAXPKT_LO = 18;
	localparam int COUNT_LO = 3;
	localparam int VALID_POS = 0;
	localparam int UFRAME_RATE_LO = 3;
	// ****************************************
	// codes and limits
	// ****************************************
	localparam logic [1:0] KIND_INTR = 2'h3;
	localparam logic [1:0] TOKEN_OUT = 2'h0;
	localparam logic [1:0] TOKEN_IN = 2'h1;
	localparam logic [14:0] COUNT_LIMIT = 15'h1000;
	localparam logic [3:0] POLL_EXP_MIN = 4'h3;
	localparam logic [1:0] RESERVED_LOW_ZERO = 2'h0;
	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic split;
		logic [1:0] kind;
		logic [1:0] token;
		logic [6:0] addr;
		logic [3:0] endp;
		logic [10:0] maxpkt;
		logic [14:0] count;
		logic valid;
	} sid_desc_t;
	typedef struct packed {
		logic split;
		logic pid_in;
		logic [6:0] addr;
		logic [3:0] endp;
		logic [10:0] len;
	} sid_txn_t;
endpackage : sid_pkg

// ===== core/sid_poll_timer.sv
// sid_poll_timer: counts microframe ticks, pulses once per polling period
// assumes: tick is a one-cycle pulse per microframe, synchronous to clk
`timescale 1ns/1ps
module sid_poll_timer #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// control
	input wire logic restart,
	input wire logic tick,
	input wire logic [3:0] exp,
	// event
	output logic fire
);
	initial begin
		if (CNT_W < 9 || CNT_W > 16) $error("sid_poll_timer: CNT_W out of range");
	end
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] last;
	logic next_fire;
	always_comb begin
		last = (CNT_W'(1) << exp) - CNT_W'(1);
		next_cnt = cnt;
		next_fire = 1'b0;
		if (restart) begin
			next_cnt = '0;
		end else if (tick) begin
			if (cnt >= last) begin
				next_cnt = '0;
				next_fire = 1'b1;
			end else begin
				next_cnt = cnt + CNT_W'(1);
			end
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			fire <= 1'b0;
		end else if (ce) begin
			cnt <= next_cnt;
			fire <= next_fire;
		end
	end
endmodule : sid_poll_timer

// ===== bench/sid_engine_model.sv
// sid_engine_model: behavioural transaction engine facing the decoder
// assumes: one request at a time, answers ack then done on rising edges
`timescale 1ns/1ps
module sid_engine_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request side
	input wire logic txn_req,
	input wire sid_pkg::sid_txn_t txn,
	// behaviour knobs
	input wire logic [1:0] slow,
	input wire logic inj_err,
	input wire logic inj_fatal,
	input wire logic short,
	// answers
	output logic txn_ack,
	output logic txn_done,
	output logic [10:0] txn_bytes,
	output logic txn_error,
	output logic txn_fatal
);
	logic [10:0] len;
	initial begin
		{txn_ack, txn_done, txn_bytes, txn_error, txn_fatal} = '0;
		forever begin
			@(posedge clk);
			if (rst || !txn_req) continue;
			len = txn.len;
			repeat (slow) @(posedge clk);
			txn_ack <= 1'b1;
			@(posedge clk);
			txn_ack <= 1'b0;
			repeat (slow) @(posedge clk);
			txn_done <= 1'b1;
			txn_bytes <= len - 11'(short);
			txn_error <= inj_err;
			txn_fatal <= inj_fatal;
			@(posedge clk);
			// qualifiers no longer hold after the pulse
			txn_done <= 1'b0;
			txn_bytes <= ~txn_bytes;
			txn_error <= ~txn_error;
			txn_fatal <= ~txn_fatal;
		end
	end
endmodule : sid_engine_model

// ===== bench/tb_top.sv
// tb_top: self-checking bench of the split descriptor decoder
// assumes: microframe tick every cycle to shorten polling waits
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_top;
	logic clk, rst, ce, load, uframe_tick, txn_req, txn_ack, txn_done, txn_error, txn_fatal;
	logic busy, wb_valid, wb_fatal, inj_err, inj_fatal, short, idle_seen;
	logic [31:0] descriptor_word0, descriptor_word1, wb_word0;
	logic [7:0] uframe;
	logic [1:0] err_budget, err_left, slow;
	logic [10:0] txn_bytes;
	logic [15:0] r;
	sid_pkg::sid_txn_t txn;
	sid_pkg::sid_desc_t desc;
	int fail_count, total_checks, lat, np, base;
	sid_decode #(.TIMER_W(16)) sid_decode_i (.clk(clk), .rst(rst), .ce(ce), .load(load),
		.descriptor_word0(descriptor_word0), .descriptor_word1(descriptor_word1),
		.uframe(uframe), .err_budget(err_budget), .uframe_tick(uframe_tick),
		.txn_req(txn_req), .txn(txn), .txn_ack(txn_ack), .txn_done(txn_done),
		.txn_bytes(txn_bytes), .txn_error(txn_error), .txn_fatal(txn_fatal), .desc(desc),
		.busy(busy), .err_left(err_left), .wb_valid(wb_valid), .wb_fatal(wb_fatal),
		.wb_word0(wb_word0));
	sid_engine_model sid_engine_model_i (.clk(clk), .rst(rst), .txn_req(txn_req), .txn(txn),
		.slow(slow), .inj_err(inj_err), .inj_fatal(inj_fatal), .short(short),
		.txn_ack(txn_ack), .txn_done(txn_done), .txn_bytes(txn_bytes),
		.txn_error(txn_error), .txn_fatal(txn_fatal));
	always #5 clk = ~clk;
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nxt
	// reserved bits and upper word filled from r
	function automatic logic [63:0] mk(input logic s, input logic [1:0] k, input logic [1:0] t,
		input logic [6:0] a, input logic [3:0] e, input logic [10:0] m, input logic [14:0] c,
		input logic v);
		return {r, r[0], s, k, t, a, e[3:1], e[0], r[2:1], m, c, r[4:3], v};
	endfunction : mk
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	task automatic run(input logic [63:0] d, input logic [7:0] uf, input logic [1:0] bud,
		input logic bad);
		int rem, len, n;
		logic seen;
		rem = d[17:3];
		lat = -1;
		np = 0;
		seen = 0;
		load = 1;
		{descriptor_word1, descriptor_word0} = d;
		uframe = uf;
		err_budget = bud;
		@(negedge clk);
		load = 0;
		`CHK(desc, {d[46:31], d[28:3], 1'b1})
		for (n = 0; n < 8000 && !wb_valid; n++) begin
			if (txn_req && !seen) begin
				len = (rem < d[28:18]) ? rem : d[28:18];
				if (lat < 0) lat = n;
				np++;
				`CHK(txn, {d[46], d[42], d[41:35], d[34:31], 11'(len)})
				if (!inj_err && !inj_fatal) rem -= len - int'(short);
			end
			seen = txn_req;
			@(negedge clk);
		end
		`CHK(wb_valid, 1'b1)
		`CHK(wb_fatal, bad)
		`CHK(wb_word0, {d[31], 2'h0, d[28:18], 15'(rem), 3'h0})
		@(negedge clk);
		`CHK({busy, desc.valid}, 2'h0)
	endtask : run
	initial begin
		{clk, load, inj_err, inj_fatal, short, slow, err_budget, uframe} = '0;
		{descriptor_word0, descriptor_word1} = '0;
		{rst, ce, uframe_tick} = 3'h7;
		r = 16'hacdc;
		repeat (10) @(negedge clk);
		rst = 0;
		// polling period per rate field
		for (int k = 0; k < 5; k++) begin
			run(mk(1, 2'h3, 2'h1, 7'h11, 4'h9, 11'h8, 15'h8, 1), k ? 8'h08 << (k - 1) : 8'h0, 0, 0);
			if (k == 0) base = lat;
			`CHK(lat - base, (1 << (3 + k)) - 8)
		end
		// clock enable low holds the polling timer
		fork
			run(mk(1, 2'h3, 2'h1, 7'h11, 4'h9, 11'h8, 15'h8, 1), 8'h0, 0, 0);
			begin
				repeat (3) @(negedge clk);
				ce = 0;
				repeat (4) @(negedge clk);
				ce = 1;
			end
		join
		`CHK(lat - base, 4)
		// descriptor with valid clear stays idle
		{descriptor_word1, descriptor_word0} = mk(0, 2'h3, 2'h0, 7'h5, 4'h3, 11'h8, 15'h10, 0);
		load = 1;
		idle_seen = 0;
		repeat (40) begin
			@(negedge clk);
			load = 0;
			idle_seen |= txn_req | busy | wb_valid;
		end
		`CHK(idle_seen, 1'b0)
		// every transfer kind, bad tokens, byte count limit
		for (int k = 0; k < 4; k++) begin
			run(mk(0, k[1:0], 2'h0, 7'h7f, 4'hf, 11'h40, 15'h20, 1), 0, 0, k != 3);
		end
		for (int k = 2; k < 4; k++) begin
			run(mk(1, 2'h3, k[1:0], 7'h1, 4'h1, 11'h40, 15'h20, 1), 0, 0, 1);
		end
		run(mk(0, 2'h3, 2'h1, 7'h2, 4'h2, 11'h400, 15'h1001, 1), 0, 0, 1);
		run(mk(0, 2'h3, 2'h0, 7'h2, 4'h2, 11'h400, 15'h1000, 1), 0, 0, 0);
		`CHK(np, 4)
		// zero packet length with payload refused, empty buffer sends one empty packet
		run(mk(0, 2'h3, 2'h0, 7'h2, 4'h2, 11'h0, 15'h8, 1), 0, 0, 1);
		run(mk(1, 2'h3, 2'h1, 7'h6, 4'h6, 11'h8, 15'h0, 1), 0, 0, 0);
		`CHK(np, 1)
		// retry budget then fatal
		inj_err = 1;
		for (int b = 0; b < 4; b++) begin
			run(mk(1, 2'h3, 2'h1, 7'h3, 4'h4, 11'h10, 15'h20, 1), 0, b[1:0], 1);
			`CHK(np, b + 1)
			`CHK(err_left, 2'h0)
		end
		inj_err = 0;
		inj_fatal = 1;
		run(mk(1, 2'h3, 2'h0, 7'h3, 4'h4, 11'h10, 15'h20, 1), 0, 2'h3, 1);
		`CHK(np, 1)
		inj_fatal = 0;
		// random descriptors, split packets within 64 bytes
		repeat (8) begin
			r = nxt(r);
			slow = r[15:14];
			short = r[13] && r[8:0] != 0;
			run(mk(r[0], 2'h3, {1'b0, r[1]}, r[8:2], r[12:9], 11'(r[5:0]) + 11'h1, 15'(r[8:0]), 1),
				0, r[7:6], 0);
		end
		finish_test();
	end
	initial begin
		#1000000;
		fail_count++;
		finish_test();
	end
endmodule : tb_top
